// ==== common/oem_cfg_pkg.sv ====
// constants, field layout and timing for the OEM configuration register block
package oem_cfg_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] REG_LOOP_CFG   = 8'h01;
	localparam logic [7:0] REG_ADDR_CFG   = 8'h02;
	localparam logic [7:0] LOOP_CFG_RESET = 8'h02;
	localparam logic [7:0] ADDR_CFG_RESET = 8'ha2;
	localparam logic [7:0] READ_UNMAPPED  = 8'h00;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int LOOP_INV_BIT   = 7;
	localparam int LOOP_GAIN_BIT  = 6;
	localparam int LOOP_REF_BIT   = 5;
	localparam int LOOP_RFB_MSB   = 4;
	localparam int LOOP_RFB_LSB   = 2;
	localparam int LOOP_DRV_BIT   = 1;
	localparam int LOOP_SHUTDOWN_POLARITY_BIT  = 0;
	localparam int ADDR_NIB_MSB   = 7;
	localparam int ADDR_NIB_LSB   = 4;
	localparam int ADDR_DLY_MSB   = 2;
	localparam int ADDR_DLY_LSB   = 0;
	// low three device address bits of this register space
	localparam logic [2:0] DEV_LOW_BITS = 3'h3;
	localparam logic [2:0] BIT_LAST     = 3'h7;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS     = 8;
	localparam int PULSE_TIME_US     = 125;
	localparam int PULSE_TICK_CYCLES = PULSE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int DLY1_TIME_US      = 17500;
	localparam int DLY2_TIME_US      = 22500;
	localparam int DLY3_TIME_US      = 27000;
	localparam int DLY4_TIME_US      = 45000;
	localparam int TICK_W            = 9;
	localparam logic [TICK_W-1:0] DLY1_TICKS = TICK_W'(DLY1_TIME_US / PULSE_TIME_US);
	localparam logic [TICK_W-1:0] DLY2_TICKS = TICK_W'(DLY2_TIME_US / PULSE_TIME_US);
	localparam logic [TICK_W-1:0] DLY3_TICKS = TICK_W'(DLY3_TIME_US / PULSE_TIME_US);
	localparam logic [TICK_W-1:0] DLY4_TICKS = TICK_W'(DLY4_TIME_US / PULSE_TIME_US);
	localparam logic [2:0] DLY_CODE_ZERO = 3'h0;
	localparam logic [2:0] DLY_CODE_1    = 3'h1;
	localparam logic [2:0] DLY_CODE_2    = 3'h2;
	localparam logic [2:0] DLY_CODE_3    = 3'h3;
	localparam logic [2:0] DLY_CODE_4    = 3'h4;
	// ************************************************************
	// state types
	// ************************************************************
	typedef enum logic [2:0] {S_IDLE, S_DEV, S_BADDR, S_WDATA, S_ACK, S_RDATA, S_MACK} ser_state_t;
	typedef enum logic [1:0] {T_IDLE, T_PULSE, T_WAIT} pulse_state_t;
endpackage

// ==== common/reset_pulse_if.sv ====
// carrier between the register block and the reset pulse timer
`timescale 1ns/1ps
interface reset_pulse_if;
	logic       fire;       // start a reset pulse
	logic       resetMode;  // output pin is in reset pulse mode
	logic [2:0] delayCode;  // clear delay selection
	logic       pinDrive;   // pull output pin low
	logic       fieldClear; // clear the reset pulse field
	modport ctrl  (output fire, resetMode, delayCode, input pinDrive, fieldClear);
	modport timer (input fire, resetMode, delayCode, output pinDrive, fieldClear);
endinterface

// ==== design/oem_config_regs.sv ====
// OEM loop and bus address configuration registers behind the two-wire serial port
`timescale 1ns/1ps
module oem_config_regs #(
	parameter int TICK_CYCLES = oem_cfg_pkg::PULSE_TICK_CYCLES
) (
	input  wire logic       sys_clk,                 // 125 MHz clock
	input  wire logic       reset_n,                 // async reset, active low
	input  wire logic       nvClear_n,               // blank storage, active low
	input  wire logic       sclIn,                   // serial clock pin
	input  wire logic       sdaIn,                   // serial data pin level
	output logic            sdaOut,                  // serial data drive value
	output logic            sdaOe_n,                 // low while pulling data low
	input  wire logic       passwordValid,           // OEM password presented
	input  wire logic       resetModeSelect,         // output pin in reset mode
	input  wire logic       resetPulseFire,          // reset field written to 111
	input  wire logic       shutdownRequest,         // shutdown asserted internally
	output logic            loopInputInvert,         // op-amp inputs inverted
	output logic            feedbackRangeQuarter,    // quarter reference swing
	output logic            feedbackReferenceSelect, // reference to supply
	output logic [2:0]      feedbackResistorCode,    // feedback resistance code
	output logic            driveDirection,          // 1 source, 0 sink
	output logic            shutdownOutput,          // shutdown pin level
	output logic [3:0]      busAddressHighNibble,    // live bus address nibble
	output logic            generalOutputPinOut,     // output pin drive value
	output logic            generalOutputPinOe_n,    // low while pulling pin low
	output logic            resetPulseFieldClear,    // clear reset field, pulse
	output logic            conversionAbort          // abort running conversion
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] sclSync, sdaSync;
	logic       sclS, sdaS, sclRise, sclFall, startCond, stopCond;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sclSync <= 3'h7;
			sdaSync <= 3'h7;
		end else begin
			sclSync <= {sclSync[1:0], sclIn};
			sdaSync <= {sdaSync[1:0], sdaIn};
		end
	end

	// stage 0 is only read by stage 1; edges use stages 1 and 2
	always_comb begin
		sclS      = sclSync[1];
		sdaS      = sdaSync[1];
		sclRise   = sclS && !sclSync[2];
		sclFall   = !sclS && sclSync[2];
		startCond = sclS && sdaSync[2] && !sdaS;
		stopCond  = sclS && !sdaSync[2] && sdaS;
	end

	// ************************************************************
	// serial slave
	// ************************************************************
	oem_cfg_pkg::ser_state_t state, next_state, afterAck, next_afterAck;
	logic [2:0] bitCnt, next_bitCnt;
	logic [7:0] shiftReg, next_shiftReg, byteAddr, next_byteAddr;
	logic [7:0] rxByte, readData;
	logic [7:0] nvLoop, next_nvLoop, nvAddr, next_nvAddr;
	logic       ackOn, next_ackOn, sdaDrive, next_sdaDrive;
	logic       next_abort, next_shutdown, wrEn;

	// read mux, password gates the data seen
	always_comb begin
		if (!passwordValid)
			readData = oem_cfg_pkg::READ_UNMAPPED;
		else if (byteAddr == oem_cfg_pkg::REG_LOOP_CFG)
			readData = nvLoop;
		else if (byteAddr == oem_cfg_pkg::REG_ADDR_CFG)
			readData = nvAddr;
		else
			readData = oem_cfg_pkg::READ_UNMAPPED;
	end

	// byte framing, acknowledge and transmit sequencing
	always_comb begin
		next_state    = state;
		next_afterAck = afterAck;
		next_bitCnt   = bitCnt;
		next_shiftReg = shiftReg;
		next_byteAddr = byteAddr;
		next_ackOn    = ackOn;
		next_sdaDrive = sdaDrive;
		next_abort    = 1'b0;
		wrEn          = 1'b0;
		rxByte        = {shiftReg[6:0], sdaS};
		// shutdown level follows the polarity bit
		next_shutdown = shutdownRequest ? nvLoop[oem_cfg_pkg::LOOP_SHUTDOWN_POLARITY_BIT]
		                                : !nvLoop[oem_cfg_pkg::LOOP_SHUTDOWN_POLARITY_BIT];
		case (state)
			oem_cfg_pkg::S_IDLE: ;
			oem_cfg_pkg::S_DEV, oem_cfg_pkg::S_BADDR, oem_cfg_pkg::S_WDATA: begin
				if (sclRise) begin
					next_shiftReg = rxByte;
					next_bitCnt   = bitCnt + 1'b1;
					if (bitCnt == oem_cfg_pkg::BIT_LAST) begin
						next_state = oem_cfg_pkg::S_ACK;
						if (state == oem_cfg_pkg::S_DEV) begin
							// compare against the live nibble
							if (rxByte[7:1] != {nvAddr[oem_cfg_pkg::ADDR_NIB_MSB:
							    oem_cfg_pkg::ADDR_NIB_LSB], oem_cfg_pkg::DEV_LOW_BITS})
								next_state = oem_cfg_pkg::S_IDLE;
							next_afterAck = rxByte[0] ? oem_cfg_pkg::S_RDATA
							                          : oem_cfg_pkg::S_BADDR;
						end else if (state == oem_cfg_pkg::S_BADDR) begin
							next_byteAddr = rxByte;
							next_afterAck = oem_cfg_pkg::S_WDATA;
						end else begin
							wrEn          = passwordValid;
							next_abort    = passwordValid
							             && byteAddr == oem_cfg_pkg::REG_LOOP_CFG;
							next_byteAddr = byteAddr + 1'b1;
							next_afterAck = oem_cfg_pkg::S_WDATA;
						end
					end
				end
			end
			oem_cfg_pkg::S_ACK: begin
				if (sclFall) begin
					if (!ackOn) begin
						next_ackOn    = 1'b1;
						next_sdaDrive = 1'b1;
					end else begin
						next_ackOn    = 1'b0;
						next_state    = afterAck;
						next_bitCnt   = '0;
						next_sdaDrive = 1'b0;
						if (afterAck == oem_cfg_pkg::S_RDATA) begin
							next_shiftReg = readData;
							next_sdaDrive = !readData[7];
						end
					end
				end
			end
			oem_cfg_pkg::S_RDATA: begin
				if (sclFall) begin
					if (bitCnt == oem_cfg_pkg::BIT_LAST) begin
						next_sdaDrive = 1'b0;
						next_state    = oem_cfg_pkg::S_MACK;
						next_byteAddr = byteAddr + 1'b1;
					end else begin
						next_shiftReg = {shiftReg[6:0], 1'b0};
						next_sdaDrive = !shiftReg[6];
						next_bitCnt   = bitCnt + 1'b1;
					end
				end
			end
			oem_cfg_pkg::S_MACK: begin
				// host ack reuses the ack release path to load the next byte
				if (sclRise) begin
					if (sdaS) begin
						next_state = oem_cfg_pkg::S_IDLE;
					end else begin
						next_state    = oem_cfg_pkg::S_ACK;
						next_ackOn    = 1'b1;
						next_afterAck = oem_cfg_pkg::S_RDATA;
					end
				end
			end
			default: next_state = oem_cfg_pkg::S_IDLE;
		endcase
		// bus conditions override any byte in flight
		if (startCond) begin
			next_state    = oem_cfg_pkg::S_DEV;
			next_bitCnt   = '0;
			next_ackOn    = 1'b0;
			next_sdaDrive = 1'b0;
		end else if (stopCond) begin
			next_state    = oem_cfg_pkg::S_IDLE;
			next_ackOn    = 1'b0;
			next_sdaDrive = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state           <= oem_cfg_pkg::S_IDLE;
			afterAck        <= oem_cfg_pkg::S_IDLE;
			bitCnt          <= '0;
			shiftReg        <= '0;
			byteAddr        <= '0;
			ackOn           <= 1'b0;
			sdaDrive        <= 1'b0;
			conversionAbort <= 1'b0;
			shutdownOutput  <= 1'b0;
		end else begin
			state           <= next_state;
			afterAck        <= next_afterAck;
			bitCnt          <= next_bitCnt;
			shiftReg        <= next_shiftReg;
			byteAddr        <= next_byteAddr;
			ackOn           <= next_ackOn;
			sdaDrive        <= next_sdaDrive;
			conversionAbort <= next_abort;
			shutdownOutput  <= next_shutdown;
		end
	end

	// ************************************************************
	// non-volatile storage
	// ************************************************************
	// only the storage blank clears these; a warm reset leaves them alone
	always_comb begin
		next_nvLoop = nvLoop;
		next_nvAddr = nvAddr;
		if (wrEn && byteAddr == oem_cfg_pkg::REG_LOOP_CFG)
			next_nvLoop = rxByte;
		if (wrEn && byteAddr == oem_cfg_pkg::REG_ADDR_CFG)
			next_nvAddr = rxByte;
	end

	always_ff @(posedge sys_clk or negedge nvClear_n) begin
		if (!nvClear_n) begin
			nvLoop <= oem_cfg_pkg::LOOP_CFG_RESET;
			nvAddr <= oem_cfg_pkg::ADDR_CFG_RESET;
		end else begin
			nvLoop <= next_nvLoop;
			nvAddr <= next_nvAddr;
		end
	end

	// ************************************************************
	// field outputs and reset pulse timer
	// ************************************************************
	reset_pulse_if rp ();

	assign loopInputInvert         = nvLoop[oem_cfg_pkg::LOOP_INV_BIT];
	assign feedbackRangeQuarter    = nvLoop[oem_cfg_pkg::LOOP_GAIN_BIT];
	assign feedbackReferenceSelect = nvLoop[oem_cfg_pkg::LOOP_REF_BIT];
	assign feedbackResistorCode    = nvLoop[oem_cfg_pkg::LOOP_RFB_MSB:oem_cfg_pkg::LOOP_RFB_LSB];
	assign driveDirection          = nvLoop[oem_cfg_pkg::LOOP_DRV_BIT];
	assign busAddressHighNibble    = nvAddr[oem_cfg_pkg::ADDR_NIB_MSB:oem_cfg_pkg::ADDR_NIB_LSB];
	assign sdaOut                  = 1'b0;
	assign sdaOe_n                 = !sdaDrive;
	assign rp.fire                 = resetPulseFire;
	assign rp.resetMode            = resetModeSelect;
	assign rp.delayCode            = nvAddr[oem_cfg_pkg::ADDR_DLY_MSB:oem_cfg_pkg::ADDR_DLY_LSB];
	assign generalOutputPinOut     = 1'b0;
	assign generalOutputPinOe_n    = !rp.pinDrive;
	assign resetPulseFieldClear    = rp.fieldClear;

	reset_pulse_timer #(.TICK_CYCLES(TICK_CYCLES)) pulseTimer (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.tp      (rp.timer)
	);

	// ************************************************************
	// checks
	// ************************************************************
	a_write_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!passwordValid |=> $stable(nvLoop) && $stable(nvAddr))
		else $error("register changed without password");
	a_abort_on_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$changed(nvLoop) |-> conversionAbort)
		else $error("loop write without conversion abort");
	a_shutdown_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
		// the edge that releases reset still loads the reset level, so skip that sample
		$stable(nvLoop) ##1 ($stable(nvLoop) && $past(reset_n))
		|-> shutdownOutput == ($past(shutdownRequest) ~^ nvLoop[oem_cfg_pkg::LOOP_SHUTDOWN_POLARITY_BIT]))
		else $error("shutdown level does not follow polarity");
	a_addr_ack: assert property (@(posedge sys_clk) disable iff (!reset_n)
		state == oem_cfg_pkg::S_DEV && sclRise && bitCnt == oem_cfg_pkg::BIT_LAST
		&& !startCond && !stopCond
		&& rxByte[7:1] == {busAddressHighNibble, oem_cfg_pkg::DEV_LOW_BITS}
		|=> state == oem_cfg_pkg::S_ACK)
		else $error("own address not acknowledged");
	a_bit3_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$changed(nvAddr[3]) |-> $stable(busAddressHighNibble) || $past(wrEn))
		else $error("spare address bit disturbed");
endmodule // oem_config_regs

// ==== design/reset_pulse_timer.sv ====
// reset pulse on the general output pin and the delayed field clear
`timescale 1ns/1ps
module reset_pulse_timer #(
	parameter int TICK_CYCLES = oem_cfg_pkg::PULSE_TICK_CYCLES
) (
	input  wire logic   sys_clk, // system clock
	input  wire logic   reset_n, // async reset, active low
	reset_pulse_if.timer tp      // request and pulse signals
);
	localparam int DIV_W = $clog2(TICK_CYCLES + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	oem_cfg_pkg::pulse_state_t state, next_state;
	logic [DIV_W-1:0]               div, next_div;
	logic [oem_cfg_pkg::TICK_W-1:0] ticks, next_ticks, delayTicks;
	logic                           next_pinDrive, next_fieldClear, tick;

	// ************************************************************
	// pulse sequencer
	// ************************************************************
	// one 125 us divider times both the pulse and the clear delay
	always_comb begin
		next_state      = state;
		next_div        = div;
		next_ticks      = ticks;
		next_fieldClear = 1'b0;
		tick            = (div == DIV_LAST);
		case (tp.delayCode)
			oem_cfg_pkg::DLY_CODE_1: delayTicks = oem_cfg_pkg::DLY1_TICKS;
			oem_cfg_pkg::DLY_CODE_2: delayTicks = oem_cfg_pkg::DLY2_TICKS;
			oem_cfg_pkg::DLY_CODE_3: delayTicks = oem_cfg_pkg::DLY3_TICKS;
			oem_cfg_pkg::DLY_CODE_4: delayTicks = oem_cfg_pkg::DLY4_TICKS;
			default:                 delayTicks = '0;
		endcase
		if (state != oem_cfg_pkg::T_IDLE)
			next_div = tick ? '0 : div + 1'b1;
		case (state)
			oem_cfg_pkg::T_IDLE: begin
				if (tp.fire && tp.resetMode) begin
					next_state = oem_cfg_pkg::T_PULSE;
					next_div   = '0;
					next_ticks = '0;
				end
			end
			oem_cfg_pkg::T_PULSE: begin
				if (tick) begin
					if (delayTicks == '0) begin
						next_fieldClear = 1'b1;
						next_state      = oem_cfg_pkg::T_IDLE;
					end else begin
						next_state = oem_cfg_pkg::T_WAIT;
					end
				end
			end
			oem_cfg_pkg::T_WAIT: begin
				if (tick) begin
					next_ticks = ticks + 1'b1;
					if (ticks + 1'b1 == delayTicks) begin
						next_fieldClear = 1'b1;
						next_state      = oem_cfg_pkg::T_IDLE;
					end
				end
			end
			default: next_state = oem_cfg_pkg::T_IDLE;
		endcase
		// leaving reset mode drops the sequence, nothing is cleared
		if (!tp.resetMode && state != oem_cfg_pkg::T_IDLE) begin
			next_state      = oem_cfg_pkg::T_IDLE;
			next_fieldClear = 1'b0;
		end
		next_pinDrive = (next_state == oem_cfg_pkg::T_PULSE);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state         <= oem_cfg_pkg::T_IDLE;
			div           <= '0;
			ticks         <= '0;
			tp.pinDrive   <= 1'b0;
			tp.fieldClear <= 1'b0;
		end else begin
			state         <= next_state;
			div           <= next_div;
			ticks         <= next_ticks;
			tp.pinDrive   <= next_pinDrive;
			tp.fieldClear <= next_fieldClear;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	logic [DIV_W:0] lowCnt;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			lowCnt <= '0;
		else
			lowCnt <= tp.pinDrive ? lowCnt + 1'b1 : '0;
	end

	a_pulse_length: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(tp.pinDrive) && $past(tp.resetMode) |-> lowCnt == (DIV_W+1)'(TICK_CYCLES))
		else $error("reset pulse length wrong");
	a_mode_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!tp.resetMode |=> !tp.pinDrive && !tp.fieldClear)
		else $error("pulse activity outside reset mode");
	a_zero_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$fell(tp.pinDrive) && $past(tp.resetMode) && tp.resetMode
		&& tp.delayCode == oem_cfg_pkg::DLY_CODE_ZERO |-> tp.fieldClear)
		else $error("zero delay clear missing");
endmodule // reset_pulse_timer

// ==== test/bus_host_model.sv ====
// two-wire host controller model driving the serial management port
`timescale 1ns/1ps
module bus_host_model (
	input  wire logic sys_clk, // system clock
	input  wire logic sdaLine, // resolved data wire, pulled up
	output logic      sclLine, // serial clock, idle high
	output logic      sdaRel   // 1 releases data, 0 pulls low
);
	// ************************************************************
	// bit level: scl phases of 8 clocks, above the 4 clock minimum
	// ************************************************************
	initial begin
		sclLine = 1'b1;
		sdaRel  = 1'b1;
	end
	task automatic q(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// data moves only while scl is low, sampled mid high phase
	task automatic bit_io(input logic b, output logic r);
		q(2);
		sdaRel <= b;
		q(6);
		sclLine <= 1'b1;
		q(4);
		r = sdaLine;
		q(4);
		sclLine <= 1'b0;
	endtask
	// start or repeated start: sda falls while scl is high
	task automatic start();
		q(2);
		sdaRel <= 1'b1;
		q(6);
		sclLine <= 1'b1;
		q(4);
		sdaRel <= 1'b0;
		q(4);
		sclLine <= 1'b0;
	endtask
	task automatic stop();
		q(2);
		sdaRel <= 1'b0;
		q(6);
		sclLine <= 1'b1;
		q(4);
		sdaRel <= 1'b1;
		q(8);
	endtask
	// eight bits msb first, then the ninth bit: host ack bit or device ack
	task automatic byte_io(input logic [7:0] b, input logic a, output logic [7:0] r,
		output logic ack);
		logic k;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r[i]);
		end
		bit_io(a, k);
		ack = !k;
	endtask
	// ************************************************************
	// register transfers at device address {nib, 011, rw}
	// ************************************************************
	task automatic wr(input logic [3:0] nib, input logic [7:0] a, input logic [7:0] d,
		output logic ok);
		logic [7:0] r;
		logic k0, k1, k2;
		start();
		byte_io({nib, 3'h3, 1'b0}, 1'b1, r, k0);
		byte_io(a, 1'b1, r, k1);
		byte_io(d, 1'b1, r, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask
	task automatic rd(input logic [3:0] nib, input logic [7:0] a, output logic [7:0] d,
		output logic ok);
		logic k0, k1, k2, k3;
		start();
		byte_io({nib, 3'h3, 1'b0}, 1'b1, d, k0);
		byte_io(a, 1'b1, d, k1);
		start();
		byte_io({nib, 3'h3, 1'b1}, 1'b1, d, k2);
		byte_io(8'hff, 1'b1, d, k3);
		stop();
		ok = k0 & k1 & k2;
	endtask
	// two-byte read: host acks the first byte, nacks the second
	task automatic rd2(input logic [3:0] nib, input logic [7:0] a, output logic [15:0] d,
		output logic ok);
		logic [7:0] r;
		logic k0, k1, k2, k3, k4;
		start();
		byte_io({nib, 3'h3, 1'b0}, 1'b1, r, k0);
		byte_io(a, 1'b1, r, k1);
		start();
		byte_io({nib, 3'h3, 1'b1}, 1'b1, r, k2);
		byte_io(8'hff, 1'b0, d[15:8], k3);
		byte_io(8'hff, 1'b1, d[7:0], k4);
		stop();
		ok = k0 & k1 & k2;
	endtask
endmodule // bus_host_model

// ==== test/tb_laser_ctrl_oem_config_regs.sv ====
// self-checking bench for the OEM configuration register block
`timescale 1ns/1ps
module tb_laser_ctrl_oem_config_regs;
	localparam int TICK = 20;
	logic       sys_clk, reset_n, nvClear_n, passwordValid, resetModeSelect;
	logic       resetPulseFire, shutdownRequest, sclLine, sdaRel, sdaLine, sdaOut, sdaOe_n;
	logic       loopInputInvert, feedbackRangeQuarter, feedbackReferenceSelect, driveDirection;
	logic       shutdownOutput, generalOutputPinOut, generalOutputPinOe_n;
	logic       resetPulseFieldClear, conversionAbort;
	logic [2:0] feedbackResistorCode;
	logic [3:0] busAddressHighNibble;
	int         num_errors, n_compared, cycles, aborts;
	// open-drain data wire with pull-up
	assign sdaLine = sdaRel & (sdaOe_n | sdaOut);
	bus_host_model host (.sys_clk(sys_clk), .sdaLine(sdaLine), .sclLine(sclLine), .sdaRel(sdaRel));
	oem_config_regs #(.TICK_CYCLES(TICK)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.nvClear_n(nvClear_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe_n(sdaOe_n), .passwordValid(passwordValid), .resetModeSelect(resetModeSelect),
		.resetPulseFire(resetPulseFire), .shutdownRequest(shutdownRequest),
		.loopInputInvert(loopInputInvert), .feedbackRangeQuarter(feedbackRangeQuarter),
		.feedbackReferenceSelect(feedbackReferenceSelect),
		.feedbackResistorCode(feedbackResistorCode), .driveDirection(driveDirection),
		.shutdownOutput(shutdownOutput), .busAddressHighNibble(busAddressHighNibble),
		.generalOutputPinOut(generalOutputPinOut), .generalOutputPinOe_n(generalOutputPinOe_n),
		.resetPulseFieldClear(resetPulseFieldClear), .conversionAbort(conversionAbort));
	// ************************************************************
	// clock, abort counter and hang guard
	// ************************************************************
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (conversionAbort === 1'b1) aborts++;
		if (cycles == 90000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (num_errors == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// clear wait in clocks: typical us over the 125 us tick
	function automatic int dly(input logic [2:0] c);
		case (c)
			3'h1: return 17500 / 125 * TICK;
			3'h2: return 22500 / 125 * TICK;
			3'h3: return 27000 / 125 * TICK;
			3'h4: return 45000 / 125 * TICK;
			default: return 0;
		endcase
	endfunction
	// pin low time and release-to-clear gap, sampled on the falling edge
	task automatic fire(input int lim, output int low, output int gap);
		low = 0;
		gap = 0;
		resetPulseFire <= 1'b1;
		@(posedge sys_clk);
		resetPulseFire <= 1'b0;
		@(negedge sys_clk);
		while (generalOutputPinOe_n === 1'b0 && low < 100) begin
			low++;
			@(negedge sys_clk);
		end
		while (resetPulseFieldClear !== 1'b1 && gap < lim) begin
			gap++;
			@(negedge sys_clk);
		end
	endtask
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		logic [7:0] v, d, last;
		logic [15:0] w;
		logic       ok;
		int         a0, low, gap, e;
		{reset_n, nvClear_n, resetPulseFire, shutdownRequest} = 4'h0;
		{passwordValid, resetModeSelect} = 2'h0;
		v = $urandom(32'hefc1);
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		nvClear_n <= 1'b1;
		passwordValid <= 1'b1;
		host.q(4);
		host.rd(4'ha, 8'h02, d, ok);
		check(d, 8'ha2);
		check({4'h0, busAddressHighNibble}, 8'h0a);
		host.rd(4'ha, 8'h01, d, ok);
		check(d, 8'h02);
		// corner codes first, then random, drive and reference kept opposite
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h02 : (i == 1) ? 8'hfd : 8'($urandom);
			v[1] = !v[5];
			a0 = aborts;
			host.wr(4'ha, 8'h01, v, ok);
			check({loopInputInvert, feedbackRangeQuarter, feedbackReferenceSelect,
				feedbackResistorCode, driveDirection, 1'b0}, {v[7:1], 1'b0});
			check(8'(aborts - a0), 8'h01);
			shutdownRequest <= 1'($urandom);
			host.q(3);
			check({7'h0, shutdownOutput}, {7'h0, shutdownRequest ~^ v[0]});
			host.rd(4'ha, 8'h01, d, ok);
			check(d, v);
		end
		last = v;
		// no password: write ignored, read gives zero
		passwordValid <= 1'b0;
		a0 = aborts;
		host.wr(4'ha, 8'h01, ~last, ok);
		check(8'(aborts - a0), 8'h00);
		host.rd(4'ha, 8'h01, d, ok);
		check(d, 8'h00);
		check({loopInputInvert, feedbackRangeQuarter, feedbackReferenceSelect,
			feedbackResistorCode, driveDirection, 1'b0}, {last[7:1], 1'b0});
		passwordValid <= 1'b1;
		// new bus address answers at once, old one goes silent
		a0 = aborts;
		host.wr(4'ha, 8'h02, 8'hba, ok);
		check({4'h0, busAddressHighNibble}, 8'h0b);
		check(8'(aborts - a0), 8'h00);
		host.rd(4'ha, 8'h02, d, ok);
		check({7'h0, ok}, 8'h00);
		host.rd(4'hb, 8'h02, d, ok);
		check(d, 8'hba);
		check({7'h0, ok}, 8'h01);
		// burst read: host ack steps the byte address from loop to address register
		host.rd2(4'hb, 8'h01, w, ok);
		check(w[15:8], last);
		check(w[7:0], 8'hba);
		// storage survives a reset
		reset_n <= 1'b0;
		host.q(3);
		reset_n <= 1'b1;
		host.q(4);
		host.rd(4'hb, 8'h02, d, ok);
		check(d, 8'hba);
		host.rd(4'hb, 8'h01, d, ok);
		check(d, last);
		// clear delay codes 0 to 4, then reset mode off
		resetModeSelect <= 1'b1;
		for (int c = 0; c < 5; c++) begin
			host.wr((c == 0) ? 4'hb : 4'ha, 8'h02, {5'h14, 3'(c)}, ok);
			e = dly(3'(c));
			fire(e + e / 10 + 4, low, gap);
			check(8'(low), 8'(TICK));
			check({7'h0, generalOutputPinOut}, 8'h00);
			check({7'h0, gap >= e - e / 10 && gap <= e + e / 10 + 1}, 8'h01);
		end
		resetModeSelect <= 1'b0;
		host.q(2);
		fire(400, low, gap);
		check(8'(low), 8'h00);
		check({7'h0, gap == 400}, 8'h01);
		close_out();
	end
endmodule // tb_laser_ctrl_oem_config_regs
